// ---- include/dbgx_pkg.sv ----
package dbgx_pkg;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam logic [AXI_ADDR_W-1:0] OFS_CONTROL = 8'h0c;
  localparam logic [AXI_ADDR_W-1:0] OFS_CMP_B_EXT = 8'h10;
  localparam logic [AXI_ADDR_W-1:0] OFS_CMP_C_EXT = 8'h14;
  localparam logic [AXI_ADDR_W-1:0] OFS_FIFO_EXT = 8'h18;
  localparam logic [AXI_ADDR_W-1:0] OFS_FIFO_HIGH = 8'h1c;
  localparam logic [AXI_ADDR_W-1:0] OFS_FIFO_LOW = 8'h20;
  localparam logic [AXI_ADDR_W-1:0] OFS_STATUS = 8'h24;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_ARM_BIT = 6;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'hf1;
  localparam int DIR_ENABLE_BIT = 7;
  localparam int DIR_VALUE_BIT = 6;
  localparam logic [7:0] DIR_EXT_WRITE_MASK = 8'hc0;
  localparam int FX_PAGED_BIT = 7;
  localparam int FX_ADDRESS_BIT_SIXTEEN_BIT = 0;
  localparam int STATUS_SECURE_BIT = 7;
  localparam logic [7:0] EXT_RESET_VALUE = 8'h00;

  // ----------------------------------------------------------------
  // Captured address layout
  // ----------------------------------------------------------------
  localparam int CORE_ADDR_W = 16;
  localparam int TRACE_ADDR_W = 17;
  localparam int PAGE_W = 3;
  localparam int PAGE_LOW_W = 14;
  localparam int FIFO_DEPTH_DEFAULT = 8;

endpackage

// ---- src/dbgx_dir_cmp.sv ----
`timescale 1ns/1ps

// Address comparator with read/write qualification
module dbgx_dir_cmp
  import dbgx_pkg::*;
#(
  parameter bit FULL_MODE_OVERRIDE = 1'b0
)
(
  input wire logic [CORE_ADDR_W-1:0] bus_addr,
  input wire logic bus_rnw,
  input wire logic bus_valid,
  input wire logic [CORE_ADDR_W-1:0] cmp_addr,
  input wire logic dir_enable,
  input wire logic dir_value,
  input wire logic full_mode,
  input wire logic comp_a_direction_enable,
  input wire logic comp_a_direction_value,
  output logic hit
);

  logic use_enable;
  logic use_value;
  logic dir_ok;

  always_comb
  begin
    use_enable = dir_enable;
    use_value = dir_value;
    // R6 comparator A qualifies in full modes
    if (FULL_MODE_OVERRIDE && full_mode)
    begin
      use_enable = comp_a_direction_enable;
      use_value = comp_a_direction_value;
    end
    // R5 R8 value selects read or write
    dir_ok = !use_enable || (bus_rnw == use_value);
    // R17 address and direction both needed
    hit = bus_valid && (bus_addr == cmp_addr) && dir_ok;
  end

endmodule

// ---- src/dbgx_regs.sv ----
`timescale 1ns/1ps

// Overview of operation
// R1 - Power-on or ordinary reset clears both comparator and FIFO extensions.
// R2 - After an end-of-run reset the extension contents are undefined.
// R3 - End-of-trace reset with enable set, begin select clear keeps contents.
// R4 - Comparator B bit 7 enables read/write qualification of matching.
// R5 - Comparator B bit 6 picks write (0) or read (1); unused when disabled.
// R6 - In full modes comparator A direction bits replace comparator B's.
// R7 - Comparator C bit 7 enables read/write qualification of matching.
// R8 - Comparator C bit 6 picks write (0) or read (1); unused when disabled.
// R9 - Reserved bits are read-only and always read zero.
// R10 - FIFO extension bit 7 shows whether the current word was paged.
// R11 - Unpaged words hold event data or a 17-bit address with bit 16 zero.
// R12 - Paged words hold page number on top, CPU address bits 13:0 below.
// R13 - FIFO extension bit 0 shows bit 16 of the captured address.
// R14 - The debug control register sits at offset 0xC.
// R15 - Software reads extension and high bytes before low; low pops FIFO.
// R16 - Module enable turns the block on; forced zero while secured.
// R17 - Match needs address equality and, if enabled, matching direction.
module dbgx_regs
  import dbgx_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEFAULT
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reset_end_run,
  input wire logic begin_select,
  input wire logic device_secure,
  input wire logic full_mode,
  input wire logic comp_a_direction_enable,
  input wire logic comp_a_direction_value,
  input wire logic [CORE_ADDR_W-1:0] cmp_b_addr,
  input wire logic [CORE_ADDR_W-1:0] cmp_c_addr,
  input wire logic [CORE_ADDR_W-1:0] core_addr,
  input wire logic core_rnw,
  input wire logic core_valid,
  input wire logic capture_valid,
  input wire logic capture_page_sel,
  input wire logic [PAGE_W-1:0] capture_page,
  input wire logic [CORE_ADDR_W-1:0] capture_addr,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [AXI_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic module_enable,
  output logic match_b,
  output logic match_c
);

  localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(FIFO_DEPTH);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(FIFO_DEPTH - 1);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [AXI_DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic aw_got;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [7:0] w_data;
    logic w_lane0;
    logic [7:0] control;
    logic [7:0] cmp_b_ext;
    logic [7:0] cmp_c_ext;
    logic [FIFO_DEPTH-1:0][TRACE_ADDR_W:0] fifo;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
    logic match_b;
    logic match_c;
  } dbgx_state_t;

  dbgx_state_t state_reg;
  dbgx_state_t state_next;

  logic hit_b;
  logic hit_c;
  logic retain;
  logic push;
  logic pop;
  logic [TRACE_ADDR_W:0] head;
  logic [TRACE_ADDR_W:0] new_word;
  logic [7:0] rbyte;
  logic rd_ok;

  // ----------------------------------------------------------------
  // Comparators
  // ----------------------------------------------------------------
  // R4 comparator B qualification
  dbgx_dir_cmp #(
    .FULL_MODE_OVERRIDE(1'b1)
  ) u_cmp_b (
    .bus_addr(core_addr),
    .bus_rnw(core_rnw),
    .bus_valid(core_valid && state_reg.control[CTRL_ENABLE_BIT]),
    .cmp_addr(cmp_b_addr),
    .dir_enable(state_reg.cmp_b_ext[DIR_ENABLE_BIT]),
    .dir_value(state_reg.cmp_b_ext[DIR_VALUE_BIT]),
    .full_mode(full_mode),
    .comp_a_direction_enable(comp_a_direction_enable),
    .comp_a_direction_value(comp_a_direction_value),
    .hit(hit_b)
  );

  // R7 comparator C qualification
  dbgx_dir_cmp #(
    .FULL_MODE_OVERRIDE(1'b0)
  ) u_cmp_c (
    .bus_addr(core_addr),
    .bus_rnw(core_rnw),
    .bus_valid(core_valid && state_reg.control[CTRL_ENABLE_BIT]),
    .cmp_addr(cmp_c_addr),
    .dir_enable(state_reg.cmp_c_ext[DIR_ENABLE_BIT]),
    .dir_value(state_reg.cmp_c_ext[DIR_VALUE_BIT]),
    .full_mode(full_mode),
    .comp_a_direction_enable(comp_a_direction_enable),
    .comp_a_direction_value(comp_a_direction_value),
    .hit(hit_c)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    retain = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    rbyte = 8'h00;
    rd_ok = 1'b1;
    head = state_reg.fifo[state_reg.rd_ptr];
    // R11 R12 captured word layout
    if (capture_page_sel)
    begin
      new_word = {1'b1, capture_page, capture_addr[PAGE_LOW_W-1:0]};
    end
    else
    begin
      new_word = {1'b0, 1'b0, capture_addr};
    end
    if (rst)
    begin
      // R3 end-of-trace retention
      retain = reset_end_run && state_reg.control[CTRL_ENABLE_BIT]
               && !begin_select;
      state_next = '0;
      // R2 other end-of-run resets clear too
      if (retain)
      begin
        state_next.control = state_reg.control;
        state_next.cmp_b_ext = state_reg.cmp_b_ext;
        state_next.cmp_c_ext = state_reg.cmp_c_ext;
        state_next.fifo = state_reg.fifo;
        state_next.wr_ptr = state_reg.wr_ptr;
        state_next.rd_ptr = state_reg.rd_ptr;
        state_next.count = state_reg.count;
      end
      else
      begin
        // R1 clear on ordinary reset
        state_next.cmp_b_ext = EXT_RESET_VALUE;
        state_next.cmp_c_ext = EXT_RESET_VALUE;
      end
    end
    else
    begin
      state_next.match_b = hit_b;
      state_next.match_c = hit_c;

      // Write channels, taken in either order
      if (s_axi_awvalid && state_reg.awready)
      begin
        state_next.aw_got = 1'b1;
        state_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && state_reg.wready)
      begin
        state_next.w_got = 1'b1;
        state_next.w_data = s_axi_wdata[7:0];
        state_next.w_lane0 = s_axi_wstrb[0];
      end
      if (state_reg.bvalid && s_axi_bready)
      begin
        state_next.bvalid = 1'b0;
      end
      if (state_reg.aw_got && state_reg.w_got && !state_reg.bvalid)
      begin
        state_next.aw_got = 1'b0;
        state_next.w_got = 1'b0;
        state_next.bvalid = 1'b1;
        state_next.bresp = RESP_OKAY;
        // R14 control register offset
        if (state_reg.aw_addr == OFS_CONTROL)
        begin
          if (state_reg.w_lane0)
          begin
            state_next.control = state_reg.w_data & CTRL_WRITE_MASK;
          end
        end
        else if (state_reg.aw_addr == OFS_CMP_B_EXT)
        begin
          // R9 reserved bits not stored
          if (state_reg.w_lane0)
          begin
            state_next.cmp_b_ext = state_reg.w_data & DIR_EXT_WRITE_MASK;
          end
        end
        else if (state_reg.aw_addr == OFS_CMP_C_EXT)
        begin
          if (state_reg.w_lane0)
          begin
            state_next.cmp_c_ext = state_reg.w_data & DIR_EXT_WRITE_MASK;
          end
        end
        else if (state_reg.aw_addr == OFS_FIFO_EXT
                 || state_reg.aw_addr == OFS_FIFO_HIGH
                 || state_reg.aw_addr == OFS_FIFO_LOW
                 || state_reg.aw_addr == OFS_STATUS)
        begin
          state_next.bresp = RESP_OKAY;
        end
        else
        begin
          state_next.bresp = RESP_SLVERR;
        end
      end
      // R16 secured device forces enable off
      if (device_secure)
      begin
        state_next.control[CTRL_ENABLE_BIT] = 1'b0;
      end

      // Read channel
      if (state_reg.rvalid && s_axi_rready)
      begin
        state_next.rvalid = 1'b0;
      end
      if (s_axi_arvalid && state_reg.arready)
      begin
        if (s_axi_araddr == OFS_CONTROL)
        begin
          rbyte = state_reg.control;
        end
        else if (s_axi_araddr == OFS_CMP_B_EXT)
        begin
          rbyte = state_reg.cmp_b_ext;
        end
        else if (s_axi_araddr == OFS_CMP_C_EXT)
        begin
          rbyte = state_reg.cmp_c_ext;
        end
        else if (s_axi_araddr == OFS_FIFO_EXT)
        begin
          // R10 paged flag and R13 address bit sixteen
          if (state_reg.count != '0)
          begin
            rbyte[FX_PAGED_BIT] = head[TRACE_ADDR_W];
            rbyte[FX_ADDRESS_BIT_SIXTEEN_BIT] = head[TRACE_ADDR_W-1];
          end
        end
        else if (s_axi_araddr == OFS_FIFO_HIGH)
        begin
          if (state_reg.count != '0)
          begin
            rbyte = head[15:8];
          end
        end
        else if (s_axi_araddr == OFS_FIFO_LOW)
        begin
          // R15 low byte read advances the FIFO
          if (state_reg.count != '0)
          begin
            rbyte = head[7:0];
            pop = 1'b1;
          end
        end
        else if (s_axi_araddr == OFS_STATUS)
        begin
          rbyte = 8'(state_reg.count);
          rbyte[STATUS_SECURE_BIT] = device_secure;
        end
        else
        begin
          rd_ok = 1'b0;
        end
        state_next.rvalid = 1'b1;
        state_next.rdata = {24'h000000, rbyte};
        state_next.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
      end

      // Trace capture while enabled and armed
      push = capture_valid && state_reg.control[CTRL_ENABLE_BIT]
             && state_reg.control[CTRL_ARM_BIT]
             && (state_reg.count != CNT_FULL || pop);
      if (push)
      begin
        state_next.fifo[state_reg.wr_ptr] = new_word;
        state_next.wr_ptr = (state_reg.wr_ptr == PTR_LAST) ? '0
                            : state_reg.wr_ptr + 1'b1;
      end
      if (pop)
      begin
        state_next.rd_ptr = (state_reg.rd_ptr == PTR_LAST) ? '0
                            : state_reg.rd_ptr + 1'b1;
      end
      if (push && !pop)
      begin
        state_next.count = state_reg.count + 1'b1;
      end
      else if (pop && !push)
      begin
        state_next.count = state_reg.count - 1'b1;
      end
    end
    if (!rst)
    begin
      state_next.awready = !state_next.aw_got && !state_next.bvalid;
      state_next.wready = !state_next.w_got && !state_next.bvalid;
      state_next.arready = !state_next.rvalid;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    state_reg <= state_next;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = state_reg.awready;
  assign s_axi_wready = state_reg.wready;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_arready = state_reg.arready;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;
  assign module_enable = state_reg.control[CTRL_ENABLE_BIT];
  assign match_b = state_reg.match_b;
  assign match_c = state_reg.match_c;

endmodule

// ---- test/dbgx_core_model.sv ----
`timescale 1ns/1ps

// Core bus side: one bus cycle per call, bus scrambled when idle
module dbgx_core_model
  import dbgx_pkg::*;
(
  input wire logic clk_sys,
  output logic [CORE_ADDR_W-1:0] core_addr,
  output logic core_rnw,
  output logic core_valid
);
  initial
  begin
    core_addr = 16'h0000;
    core_rnw = 1'b0;
    core_valid = 1'b0;
  end

  task automatic cycle(input logic [15:0] a, input logic rnw);
    @(posedge clk_sys);
    core_addr <= a;
    core_rnw <= rnw;
    core_valid <= 1'b1;
    @(posedge clk_sys);
    core_valid <= 1'b0;
    core_addr <= ~a;
    core_rnw <= ~rnw;
  endtask
endmodule

// ---- test/dbgx_regs_props.sv ----
`timescale 1ns/1ps

module dbgx_regs_chk
  import dbgx_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic device_secure,
  input wire logic full_mode,
  input wire logic comp_a_direction_enable,
  input wire logic comp_a_direction_value,
  input wire logic [CORE_ADDR_W-1:0] cmp_b_addr,
  input wire logic [CORE_ADDR_W-1:0] cmp_c_addr,
  input wire logic [CORE_ADDR_W-1:0] core_addr,
  input wire logic core_rnw,
  input wire logic core_valid,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [AXI_DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic module_enable,
  input wire logic match_b,
  input wire logic match_c
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence cmp_ext_rd;
    s_axi_arvalid && s_axi_arready &&
      (s_axi_araddr == OFS_CMP_B_EXT || s_axi_araddr == OFS_CMP_C_EXT);
  endsequence
  sequence fx_rd;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_FIFO_EXT;
  endsequence
  sequence b_hit_full;
    full_mode && core_valid && module_enable && core_addr == cmp_b_addr;
  endsequence

  a_secure_forces_off:
    assert property (device_secure |=> !module_enable)
    else $error("enable set while secured");
  a_b_needs_cycle:
    assert property (!core_valid |=> !match_b)
    else $error("match b without bus cycle");
  a_c_needs_enable:
    assert property (!module_enable |=> !match_c)
    else $error("match c while disabled");
  a_b_addr_miss:
    assert property (core_addr != cmp_b_addr |=> !match_b)
    else $error("match b on other address");
  a_c_addr_miss:
    assert property (core_addr != cmp_c_addr |=> !match_c)
    else $error("match c on other address");
  a_full_dir_block:
    assert property (full_mode && comp_a_direction_enable &&
      core_rnw != comp_a_direction_value |=> !match_b)
    else $error("full mode direction ignored");
  a_full_dir_hit:
    assert property (b_hit_full ##0 (!comp_a_direction_enable ||
      core_rnw == comp_a_direction_value) |=> match_b)
    else $error("full mode hit missed");
  a_ext_rsvd_zero:
    assert property (cmp_ext_rd |=> s_axi_rvalid && s_axi_rdata[5:0] == 6'h00)
    else $error("comparator reserved bits set");
  a_fx_rsvd_zero:
    assert property (fx_rd |=> s_axi_rvalid && s_axi_rdata[6:1] == 6'h00)
    else $error("fifo reserved bits set");
endmodule

bind dbgx_regs dbgx_regs_chk dbgx_regs_chk_i (.*);

// ---- test/dbgx_regs_tb_top.sv ----
`timescale 1ns/1ps

module dbgx_regs_tb_top
  import dbgx_pkg::*;
;
  logic clk_sys, rst, reset_end_run, begin_select, device_secure, full_mode;
  logic comp_a_direction_enable, comp_a_direction_value, capture_valid;
  logic capture_page_sel, core_rnw, core_valid, module_enable, match_b;
  logic match_c, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [2:0] capture_page;
  logic [15:0] cmp_b_addr, cmp_c_addr, core_addr, capture_addr;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  int mismatches, compares;

  dbgx_regs dbgx_regs_i (.*);
  dbgx_core_model dbgx_core_model_i (
    .clk_sys(clk_sys),
    .core_addr(core_addr),
    .core_rnw(core_rnw),
    .core_valid(core_valid)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bit got;
    got = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!got)
    begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        resp = s_axi_bresp;
        got = 1'b1;
        s_axi_bready <= 1'b0;
      end
    end
  endtask

  task automatic rdr(input logic [7:0] a);
    bit got;
    got = 1'b0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!got)
    begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        got = 1'b1;
        s_axi_rready <= 1'b0;
      end
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rdr(a);
    chk(rd, e);
    chk(resp, RESP_OKAY);
  endtask

  task automatic cap(input logic ps, input logic [2:0] pg, input logic [15:0] a);
    @(posedge clk_sys);
    capture_valid <= 1'b1;
    capture_page_sel <= ps;
    capture_page <= pg;
    capture_addr <= a;
    @(posedge clk_sys);
    capture_valid <= 1'b0;
  endtask

  task automatic end_of_test();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge clk_sys);
    mismatches++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    {rst, reset_end_run, begin_select, device_secure, full_mode} = 5'h10;
    {comp_a_direction_enable, comp_a_direction_value} = 2'h0;
    {capture_valid, capture_page_sel, capture_page} = 5'h00;
    {cmp_b_addr, cmp_c_addr, capture_addr} = {3{16'h4a5c}};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h00000;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hf;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    rdc(OFS_CMP_B_EXT, 32'h00);
    rdc(OFS_CMP_C_EXT, 32'h00);
    rdc(OFS_FIFO_EXT, 32'h00);
    wr(OFS_CMP_B_EXT, 8'hff);
    rdc(OFS_CMP_B_EXT, 32'hc0);
    wr(OFS_CMP_C_EXT, 8'hff);
    rdc(OFS_CMP_C_EXT, 32'hc0);
    wr(OFS_FIFO_EXT, 8'hff);
    rdc(OFS_FIFO_EXT, 32'h00);
    wr(OFS_CONTROL, 8'hff);
    rdc(OFS_CONTROL, 32'hf1);
    wr(8'h40, 8'h01);
    chk(resp, RESP_SLVERR);
    rdr(8'h40);
    chk(resp, RESP_SLVERR);
    device_secure <= 1'b1;
    wr(OFS_CONTROL, 8'h80);
    rdc(OFS_CONTROL, 32'h00);
    rdc(OFS_STATUS, 32'h80);
    device_secure <= 1'b0;
    wr(OFS_CONTROL, 8'h80);
    chk(module_enable, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      wr(OFS_CMP_B_EXT, {i[2], i[1], 6'h00});
      wr(OFS_CMP_C_EXT, {i[2], i[1], 6'h00});
      dbgx_core_model_i.cycle(16'h4a5c, i[0]);
      @(posedge clk_sys);
      chk(match_b, !i[2] || i[0] == i[1]);
      chk(match_c, !i[2] || i[0] == i[1]);
    end
    dbgx_core_model_i.cycle(16'h4a5d, 1'b1);
    @(posedge clk_sys);
    chk({match_b, match_c}, 2'h0);
    full_mode <= 1'b1;
    comp_a_direction_enable <= 1'b1;
    dbgx_core_model_i.cycle(16'h4a5c, 1'b1);
    @(posedge clk_sys);
    chk(match_b, 1'b0);
    dbgx_core_model_i.cycle(16'h4a5c, 1'b0);
    @(posedge clk_sys);
    chk(match_b, 1'b1);
    full_mode <= 1'b0;
    comp_a_direction_enable <= 1'b0;
    wr(OFS_CONTROL, 8'hc0);
    cap(1'b1, 3'h5, 16'h3abc);
    cap(1'b0, 3'h0, 16'h1234);
    @(posedge clk_sys);
    rst <= 1'b1;
    reset_end_run <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    reset_end_run <= 1'b0;
    rdc(OFS_CMP_B_EXT, 32'hc0);
    rdc(OFS_STATUS, 32'h02);
    rdc(OFS_FIFO_EXT, 32'h81);
    rdc(OFS_FIFO_HIGH, 32'h7a);
    rdc(OFS_FIFO_LOW, 32'hbc);
    rdc(OFS_FIFO_EXT, 32'h00);
    rdc(OFS_FIFO_HIGH, 32'h12);
    rdc(OFS_FIFO_LOW, 32'h34);
    rdc(OFS_FIFO_LOW, 32'h00);
    rdc(OFS_STATUS, 32'h00);
    @(posedge clk_sys);
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    rdc(OFS_CMP_B_EXT, 32'h00);
    rdc(OFS_CONTROL, 32'h00);
    end_of_test();
  end
endmodule
